// >>> hdl/ais_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 50 MHz aclk
// Notes: definitions only
`ifndef AIS_CFG_SVH
`define AIS_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define AIS_OFF_CTRL 8'h00
`define AIS_OFF_SEL 8'h04
`define AIS_OFF_CFG 8'h08
`define AIS_OFF_DATA 8'h0C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define AIS_CTRL_EN 0
`define AIS_CTRL_START 1
`define AIS_CTRL_BUSY 2
`define AIS_CTRL_DONE 3
`define AIS_CTRL_DIFF 4
`define AIS_CTRL_BADPOS 5

// ----------------------------------------------------------------
// select field layout and codes
// ----------------------------------------------------------------
`define AIS_NEG_HI 7
`define AIS_NEG_LO 4
`define AIS_POS_HI 3
`define AIS_POS_LO 0
`define AIS_POS_TEMP 4'h8
`define AIS_POS_VDD 4'h9

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AIS_SEL_RST 8'h00
`define AIS_DATA_RST 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AIS_CLK_NS 20
`define AIS_SAMPLE_NS 2000
`define AIS_SAMPLE_CYC ((`AIS_SAMPLE_NS + `AIS_CLK_NS - 1) / `AIS_CLK_NS)
`define AIS_SAR_DIV 3'h5
`define AIS_TRACK_TICKS 2'h3

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define AIS_RESP_OKAY 2'h0
`define AIS_RESP_SLVERR 2'h2

`endif

// >>> hdl/ais_pkg.sv
// Purpose: shared types of the converter front end
// Assumes: nothing
// Notes: constants live in ais_cfg.svh
package ais_pkg;

  typedef enum logic [1:0] {
    ais_gain_half = 2'h0,
    ais_gain_one = 2'h1,
    ais_gain_two = 2'h2,
    ais_gain_four = 2'h3
  } ais_gain_t;

  typedef enum logic [3:0] {
    ais_st_idle = 4'h1,
    ais_st_track = 4'h2,
    ais_st_conv = 4'h4,
    ais_st_done = 4'h8
  } ais_sar_state_t;

endpackage

// >>> hdl/ais_conv_if.sv
// Purpose: link between register side and successive-approximation core
// Assumes: one clock
// Notes: start is a one-cycle pulse, done likewise
`timescale 1ns/1ps
`default_nettype none
interface ais_conv_if;
  logic enable;
  logic start;
  logic diff_mode;
  logic busy;
  logic done;
  logic [7:0] result;
  logic [7:0] dac_code;
  logic track;
  modport core (
    input enable,
    input start,
    input diff_mode,
    output busy,
    output done,
    output result,
    output dac_code,
    output track
  );
  modport ctrl (
    output enable,
    output start,
    output diff_mode,
    input busy,
    input done,
    input result,
    input dac_code,
    input track
  );
endinterface
`default_nettype wire

// >>> hdl/ais_mux.sv
// Purpose: input multiplexer decode and mode from the channel select
// Assumes: sel comes from a register on aclk
// Notes: all switches open while disabled
`timescale 1ns/1ps
`default_nettype none
`include "ais_cfg.svh"
module ais_mux (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [7:0] sel,
  output logic [7:0] pos_pin,
  output logic pos_temp,
  output logic pos_vdd,
  output logic pos_bad,
  output logic [7:0] neg_pin,
  output logic neg_gnd,
  output logic diff_mode
);
  logic [3:0] neg_code;
  logic [3:0] pos_code;

  // code with top bit set selects no pin
  function automatic logic [7:0] pin_dec(input logic [3:0] code);
    pin_dec = code[3] ? 8'h00 : (8'h01 << code[2:0]);
  endfunction

  assign neg_code = sel[`AIS_NEG_HI:`AIS_NEG_LO];
  assign pos_code = sel[`AIS_POS_HI:`AIS_POS_LO];

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      pos_pin <= 8'h00;
      pos_temp <= 1'b0;
      pos_vdd <= 1'b0;
      neg_pin <= 8'h00;
      neg_gnd <= 1'b0;
    end else begin
      pos_pin <= pin_dec(pos_code);
      pos_temp <= (pos_code == `AIS_POS_TEMP);
      pos_vdd <= (pos_code == `AIS_POS_VDD);
      neg_pin <= pin_dec(neg_code);
      neg_gnd <= neg_code[3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diff_mode <= 1'b1;
      pos_bad <= 1'b0;
    end else begin
      diff_mode <= ~neg_code[3];
      pos_bad <= pos_code[3] && (pos_code[2:1] != 2'h0);
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ais_sar.sv
// Purpose: 8-bit successive-approximation sequencer with track-and-hold
// Assumes: cmp_in is an asynchronous comparator level, high when input above dac
// Notes: dropping enable aborts a conversion at once
`timescale 1ns/1ps
`default_nettype none
`include "ais_cfg.svh"
module ais_sar (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmp_in,
  ais_conv_if.core cif
);
  ais_pkg::ais_sar_state_t state;
  logic cmp_s1, cmp_s2, cmp_s3, cmp_f;
  logic [2:0] div_cnt;
  logic tick;
  logic [1:0] trk;
  logic [2:0] idx;
  logic mode_q;

  // differential codes are offset binary from the array; flip msb
  function automatic logic [7:0] fmt(input logic diff, input logic [7:0] code);
    fmt = diff ? {~code[7], code[6:0]} : code;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_f <= 1'b0;
    end else begin
      cmp_s1 <= cmp_in;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3) begin
        cmp_f <= cmp_s3;
      end
    end
  end

  // sar step enable; restarted per conversion for even spacing
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ais_pkg::ais_st_idle) begin
      div_cnt <= 3'h0;
      tick <= 1'b0;
    end else if (div_cnt == `AIS_SAR_DIV - 3'h1) begin
      div_cnt <= 3'h0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 3'h1;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !cif.enable) begin
      state <= ais_pkg::ais_st_idle;
    end else begin
      case (state)
        ais_pkg::ais_st_idle: begin
          if (cif.start) state <= ais_pkg::ais_st_track;
        end
        ais_pkg::ais_st_track: begin
          if (tick && trk == `AIS_TRACK_TICKS - 2'h1) state <= ais_pkg::ais_st_conv;
        end
        ais_pkg::ais_st_conv: begin
          if (tick && idx == 3'h0) state <= ais_pkg::ais_st_done;
        end
        ais_pkg::ais_st_done: state <= ais_pkg::ais_st_idle;
        default: state <= ais_pkg::ais_st_idle;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= 1'b0;
      trk <= 2'h0;
      idx <= 3'h0;
      cif.dac_code <= 8'h00;
      cif.result <= `AIS_DATA_RST;
      cif.busy <= 1'b0;
      cif.done <= 1'b0;
      cif.track <= 1'b0;
    end else if (!cif.enable) begin
      cif.busy <= 1'b0;
      cif.done <= 1'b0;
      cif.track <= 1'b0;
    end else begin
      cif.done <= 1'b0;
      if (state == ais_pkg::ais_st_idle && cif.start) begin
        mode_q <= cif.diff_mode;
        trk <= 2'h0;
        cif.busy <= 1'b1;
        cif.track <= 1'b1;
      end
      if (state == ais_pkg::ais_st_track && tick) begin
        trk <= trk + 2'h1;
        if (trk == `AIS_TRACK_TICKS - 2'h1) begin
          cif.track <= 1'b0;
          cif.dac_code <= 8'h80;
          idx <= 3'h7;
        end
      end
      if (state == ais_pkg::ais_st_conv && tick) begin
        cif.dac_code[idx] <= cmp_f;
        if (idx == 3'h0) begin
          cif.result <= fmt(mode_q, {cif.dac_code[7:1], cmp_f});
          cif.done <= 1'b1;
          cif.busy <= 1'b0;
        end else begin
          cif.dac_code[idx - 3'h1] <= 1'b1;
          idx <= idx - 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ais_top.sv
// Purpose: converter front-end control behind an AXI4-Lite register slave
// Assumes: single 50 MHz clock, synchronous active-low reset
// Notes: analog array, comparator and switches sit outside this logic
`timescale 1ns/1ps
`default_nettype none
`include "ais_cfg.svh"
module ais_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_in,
  output logic [7:0] dac_code,
  output logic track_hold,
  output logic powerdown,
  output ais_pkg::ais_gain_t gain_sel,
  output logic [7:0] pos_pin_sel,
  output logic pos_temp_sel,
  output logic pos_vdd_sel,
  output logic [7:0] neg_pin_sel,
  output logic neg_gnd_sel
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ais_conv_if cif ();

  logic enable;
  logic [7:0] chan_sel;
  logic done_flag;
  logic start_pulse;
  logic [6:0] gap_cnt;
  logic diff_mode;
  logic pos_bad;

  logic aw_have;
  logic [7:0] aw_addr_q;
  logic w_have;
  logic [7:0] w_byte_q;
  logic w_strb0_q;
  logic do_write;
  logic wr_ctrl;
  logic wr_sel;
  logic wr_cfg;
  logic wr_hit;

  logic [7:0] rd_byte;
  logic rd_hit;

  // ----------------------------------------------------------------
  // shared address decode
  // ----------------------------------------------------------------
  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
    is_reg = (addr[7:2] == off[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // write channel capture
  // ----------------------------------------------------------------
  // address and data are taken in either order and held until both exist
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_have <= 1'b0;
      aw_addr_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_have <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_have <= 1'b0;
      w_byte_q <= 8'h00;
      w_strb0_q <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_have <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_have <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign do_write = aw_have && w_have && !s_axi_bvalid;
  assign wr_hit = is_reg(aw_addr_q, `AIS_OFF_CTRL) || is_reg(aw_addr_q, `AIS_OFF_SEL)
               || is_reg(aw_addr_q, `AIS_OFF_CFG) || is_reg(aw_addr_q, `AIS_OFF_DATA);
  assign wr_ctrl = do_write && w_strb0_q && is_reg(aw_addr_q, `AIS_OFF_CTRL);
  assign wr_sel = do_write && w_strb0_q && is_reg(aw_addr_q, `AIS_OFF_SEL);
  assign wr_cfg = do_write && w_strb0_q && is_reg(aw_addr_q, `AIS_OFF_CFG);

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AIS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `AIS_RESP_OKAY : `AIS_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= 1'b0;
    end else if (wr_ctrl) begin
      enable <= w_byte_q[`AIS_CTRL_EN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerdown <= 1'b1;
    end else begin
      powerdown <= !enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_sel <= `AIS_SEL_RST;
    end else if (wr_sel) begin
      chan_sel <= w_byte_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_sel <= ais_pkg::ais_gain_half;
    end else if (wr_cfg) begin
      gain_sel <= ais_pkg::ais_gain_t'(w_byte_q[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // conversion start and completion
  // ----------------------------------------------------------------
  // starts closer than one sample period are dropped to hold the rate cap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_pulse <= 1'b0;
      gap_cnt <= 7'h00;
    end else begin
      start_pulse <= 1'b0;
      if (gap_cnt != 7'h00) begin
        gap_cnt <= gap_cnt - 7'h01;
      end
      if (wr_ctrl && w_byte_q[`AIS_CTRL_START] && enable && !cif.busy
          && !start_pulse && gap_cnt == 7'h00) begin
        start_pulse <= 1'b1;
        gap_cnt <= 7'(`AIS_SAMPLE_CYC - 1);
      end
    end
  end

  // completion in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag <= 1'b0;
    end else if (cif.done) begin
      done_flag <= 1'b1;
    end else if (wr_ctrl && w_byte_q[`AIS_CTRL_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (is_reg(s_axi_araddr, `AIS_OFF_CTRL)) begin
      rd_byte[`AIS_CTRL_EN] = enable;
      rd_byte[`AIS_CTRL_BUSY] = cif.busy;
      rd_byte[`AIS_CTRL_DONE] = done_flag;
      rd_byte[`AIS_CTRL_DIFF] = diff_mode;
      rd_byte[`AIS_CTRL_BADPOS] = pos_bad;
    end else if (is_reg(s_axi_araddr, `AIS_OFF_SEL)) begin
      rd_byte = chan_sel;
    end else if (is_reg(s_axi_araddr, `AIS_OFF_CFG)) begin
      rd_byte = {6'h00, gain_sel};
    end else if (is_reg(s_axi_araddr, `AIS_OFF_DATA)) begin
      rd_byte = cif.result;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AIS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? `AIS_RESP_OKAY : `AIS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // multiplexer decode
  // ----------------------------------------------------------------
  ais_mux u_mux (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(enable),
    .sel(chan_sel),
    .pos_pin(pos_pin_sel),
    .pos_temp(pos_temp_sel),
    .pos_vdd(pos_vdd_sel),
    .pos_bad(pos_bad),
    .neg_pin(neg_pin_sel),
    .neg_gnd(neg_gnd_sel),
    .diff_mode(diff_mode)
  );

  // ----------------------------------------------------------------
  // successive-approximation core
  // ----------------------------------------------------------------
  assign cif.enable = enable;
  assign cif.start = start_pulse;
  assign cif.diff_mode = diff_mode;

  ais_sar u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmp_in(cmp_in),
    .cif(cif)
  );

  assign dac_code = cif.dac_code;
  assign track_hold = cif.track;

endmodule
`default_nettype wire

// >>> sim/ais_analog_model.sv
// Purpose: analog far side: pin inputs feeding the comparator
// Assumes: level is the input as an offset-binary code
// Notes: comparator output toggles while the converter is shut down
`timescale 1ns/1ps
`default_nettype none
module ais_analog_model (
  input wire logic aclk,
  input wire logic powerdown,
  input wire logic [7:0] dac_code,
  input wire logic [7:0] level,
  output logic cmp_in
);
  // ----------------------------------------------------------------
  // comparator
  // ----------------------------------------------------------------
  bit idle_pat;
  always @(posedge aclk) begin
    idle_pat <= ~idle_pat;
  end
  // pins are taken as set to analog mode and skipped by the crossbar
  // half-lsb offset, so a tie with the trial code keeps the bit
  assign cmp_in = powerdown ? idle_pat : ({level, 1'b1} > {dac_code, 1'b0});
endmodule
`default_nettype wire

// >>> sim/ais_top_assertions.sv
// Purpose: port-level checks of the converter front end
// Assumes: one clock, synchronous active-low reset
// Notes: bound to ais_top from the testbench
`timescale 1ns/1ps
`default_nettype none
module ais_top_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic powerdown,
  input wire logic track_hold,
  input wire logic [7:0] dac_code,
  input wire ais_pkg::ais_gain_t gain_sel,
  input wire logic [7:0] pos_pin_sel,
  input wire logic pos_temp_sel,
  input wire logic pos_vdd_sel,
  input wire logic [7:0] neg_pin_sel,
  input wire logic neg_gnd_sel
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // three ticks of five cycles; the divider restarts at the start pulse,
  // so the first tick lands one cycle late: 16 cycles high in all
  sequence s_track;
    track_hold[*8] ##1 track_hold[*8] ##1 !track_hold;
  endsequence
  sequence s_first_trial;
    ##[0:5] (dac_code == 8'h80);
  endsequence
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_off_open: assert property (powerdown && $past(powerdown) |->
    {pos_pin_sel, neg_pin_sel, pos_temp_sel, pos_vdd_sel, neg_gnd_sel} == 19'h0)
    else $error("switch closed during shutdown");
  chk_off_idle: assert property (powerdown && $past(powerdown) |-> !track_hold)
    else $error("tracking during shutdown");
  chk_pd_reset: assert property ($rose(aresetn) |-> powerdown)
    else $error("converter not shut down after reset");
  chk_pos_single: assert property ($onehot0({pos_pin_sel, pos_temp_sel, pos_vdd_sel}))
    else $error("more than one positive switch");
  chk_neg_single: assert property (!powerdown[*3] |-> $onehot({neg_pin_sel, neg_gnd_sel}))
    else $error("negative input not exactly one");
  chk_track_len: assert property ($rose(track_hold) |-> s_track)
    else $error("track period length wrong");
  chk_first_trial: assert property ($fell(track_hold) && !powerdown |-> s_first_trial)
    else $error("first trial code not mid scale");
  chk_gain_reset: assert property ($rose(aresetn) |-> gain_sel == ais_pkg::ais_gain_half)
    else $error("gain not half after reset");
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: self-checking bench of the converter front end
// Assumes: 50 MHz aclk, synchronous active-low reset
// Notes: level drives the analog model as an offset-binary code
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk, aresetn, cmp_in, track_hold, powerdown, pos_temp_sel, pos_vdd_sel, neg_gnd_sel;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dac_code, pos_pin_sel, neg_pin_sel, level;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  ais_pkg::ais_gain_t gain_sel;
  int error_cnt, comparisons;
  ais_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cmp_in(cmp_in), .dac_code(dac_code), .track_hold(track_hold),
    .powerdown(powerdown), .gain_sel(gain_sel), .pos_pin_sel(pos_pin_sel),
    .pos_temp_sel(pos_temp_sel), .pos_vdd_sel(pos_vdd_sel), .neg_pin_sel(neg_pin_sel),
    .neg_gnd_sel(neg_gnd_sel));
  ais_analog_model u_ana (.aclk(aclk), .powerdown(powerdown), .dac_code(dac_code),
    .level(level), .cmp_in(cmp_in));
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // leading edge keeps a released ready from being raised in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    @(posedge aclk);
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(32'(gain_sel), 32'h0);
    chk(32'(powerdown), 32'h1);
    chk({13'h0, pos_pin_sel, neg_pin_sel, pos_temp_sel, pos_vdd_sel, neg_gnd_sel}, 32'h0);
    for (int i = 1; i < 4; i++) begin
      rd_reg(8'(4 * i));
      chk(rd, 32'h0);
    end
    $display("test reset done");
  endtask
  task automatic t_gain;
    for (int g = 0; g < 4; g++) begin
      wr(8'h08, 32'(g));
      rd_reg(8'h08);
      chk(rd, 32'(g));
      chk(32'(gain_sel), 32'(g));
    end
    $display("test gain done");
  endtask
  task automatic t_mux;
    wr(8'h00, 32'h1);
    for (int p = 0; p < 16; p++) begin
      wr(8'h04, 32'h80 | 32'(p));
      rd_reg(8'h00);
      chk({22'h0, pos_vdd_sel, pos_temp_sel, pos_pin_sel}, (p < 10) ? 32'h1 << p : 32'h0);
      chk({31'h0, rd[5]}, 32'(p >= 10));
    end
    for (int n = 0; n < 16; n++) begin
      wr(8'h04, 32'(n) << 4);
      rd_reg(8'h00);
      chk({23'h0, neg_gnd_sel, neg_pin_sel}, n[3] ? 32'h100 : 32'h1 << n);
      chk({31'h0, rd[4]}, 32'(n < 8));
    end
    chk(32'(powerdown), 32'h0);
    $display("test mux done");
  endtask
  task automatic conv(input logic [7:0] sel, input logic [7:0] lvl, input logic flip,
                      input logic [7:0] exp);
    int n;
    wr(8'h04, {24'h0, sel});
    level <= lvl;
    wr(8'h00, 32'h3);
    // mode must stay as latched at the start
    if (flip) begin
      wr(8'h04, {24'h0, sel ^ 8'h80});
    end
    n = 0;
    do begin
      rd_reg(8'h00);
      n++;
    end while (!rd[3] && n < 60);
    chk({31'h0, rd[3]}, 32'h1);
    rd_reg(8'h0C);
    chk(rd, {24'h0, exp});
    wr(8'h00, 32'h9);
    rd_reg(8'h00);
    chk({31'h0, rd[3]}, 32'h0);
    // keeps starts at least 100 cycles apart
    repeat (50) @(posedge aclk);
  endtask
  task automatic t_conv;
    conv(8'h80, 8'hFF, 1'b0, 8'hFF);
    conv(8'h80, 8'h80, 1'b0, 8'h80);
    conv(8'h80, 8'h00, 1'b0, 8'h00);
    conv(8'h01, 8'hFF, 1'b0, 8'h7F);
    conv(8'h01, 8'h40, 1'b0, 8'hC0);
    conv(8'h01, 8'h00, 1'b0, 8'h80);
    conv(8'h80, 8'h40, 1'b1, 8'h40);
    $display("test conversion done");
  endtask
  task automatic t_off;
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h2);
    repeat (80) @(posedge aclk);
    rd_reg(8'h00);
    chk(rd & 32'hF, 32'h0);
    chk(32'(powerdown), 32'h1);
    chk({13'h0, pos_pin_sel, neg_pin_sel, pos_temp_sel, pos_vdd_sel, neg_gnd_sel}, 32'h0);
    wr(8'h10, 32'h1);
    chk(32'(rsp), 32'h2);
    rd_reg(8'h10);
    chk(32'(rsp), 32'h2);
    chk(rd, 32'h0);
    $display("test shutdown done");
  endtask
  task automatic t_rst2;
    wr(8'h08, 32'h3);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(gain_sel), 32'h0);
    chk(32'(powerdown), 32'h1);
    $display("test second reset done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    level = 8'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_gain();
    t_mux();
    t_conv();
    t_off();
    t_rst2();
    tally_and_finish();
  end
  // normal run is a little over a thousand cycles
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
bind ais_top ais_top_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .powerdown(powerdown),
  .track_hold(track_hold), .dac_code(dac_code), .gain_sel(gain_sel),
  .pos_pin_sel(pos_pin_sel), .pos_temp_sel(pos_temp_sel), .pos_vdd_sel(pos_vdd_sel),
  .neg_pin_sel(neg_pin_sel), .neg_gnd_sel(neg_gnd_sel));
`default_nettype wire
